/* rshc_consts.svh */
/*
 * Constants of the regulator sleep and hardware-control configuration block.
 * Assumes inclusion by bare name from SystemVerilog design files.
 */
`ifndef RSHC_CONSTS_SVH
`define RSHC_CONSTS_SVH

// Register indices; byte address is four times the index
`define RSHC_IDX_CONV_SLP   16'h4067
`define RSHC_IDX_REG_CTL    16'h4068
`define RSHC_IDX_REG_AUX    16'h4080
`define RSHC_IDX_IRQ_STS    16'h4081
`define RSHC_IDX_IRQ_MSK    16'h4082
`define RSHC_IDX_STATE      16'h4083

// Writable bit masks and reset values
`define RSHC_CS_MASK        32'h0000E37F
`define RSHC_CS_RESET       32'h00000300
`define RSHC_RC_MASK        32'h0000DFC1
`define RSHC_RC_RESET       32'h00000200
`define RSHC_AUX_MASK       32'h00011F1F
`define RSHC_AUX_RESET      32'h00000000
`define RSHC_IRQ_MASK       32'h00000007
`define RSHC_IRQ_RESET      3'h0
`define RSHC_CS_MODE_RESET  2'h3

// Converter sleep control fields
`define RSHC_CS_SLOT        15:13
`define RSHC_CS_MODE        9:8
`define RSHC_CS_VSEL        6:0

// Regulator control fields
`define RSHC_RC_ERR         15:14
`define RSHC_RC_SRC         12:11
`define RSHC_RC_VPICK       10
`define RSHC_RC_HWMODE      9:8
`define RSHC_RC_FLOAT       7
`define RSHC_RC_SWITCH      6
`define RSHC_RC_LPSEL       0

// Regulator auxiliary fields
`define RSHC_AUX_ONV        4:0
`define RSHC_AUX_SLPV       12:8
`define RSHC_AUX_ONMODE     16

// Interrupt status bits
`define RSHC_IRQ_UV         0
`define RSHC_IRQ_SLOT       1
`define RSHC_IRQ_HWC        2

// Converter sleep voltage scale
`define RSHC_CONV_BASE_MV   12'h352
`define RSHC_CONV_STEP_MV   12'h019
`define RSHC_CONV_SAT_CODE  7'h66

`endif

/* rshc_pkg.sv */
/*
 * Types of the regulator sleep and hardware-control configuration block.
 * Assumes nothing of its surroundings.
 */
package rshc_pkg;

	typedef enum logic [1:0] {
		RSHC_ACT_TRANSITION = 2'b00,
		RSHC_ACT_DISABLE    = 2'b01,
		RSHC_ACT_ENTER      = 2'b10
	} rshc_slp_act_t;

	typedef enum logic [1:0] {
		RSHC_MODE_FCCM = 2'b00,
		RSHC_MODE_AUTO = 2'b01,
		RSHC_MODE_LDO  = 2'b10,
		RSHC_MODE_HYST = 2'b11
	} rshc_conv_mode_t;

	typedef enum logic [1:0] {
		RSHC_ERR_IGNORE = 2'b00,
		RSHC_ERR_SHUT   = 2'b01,
		RSHC_ERR_RESET  = 2'b10,
		RSHC_ERR_RSVD   = 2'b11
	} rshc_err_act_t;

	typedef enum logic [2:0] {
		RSHC_SEL_NONE  = 3'b000,
		RSHC_SEL_CS    = 3'b001,
		RSHC_SEL_RC    = 3'b010,
		RSHC_SEL_AUX   = 3'b011,
		RSHC_SEL_ISTS  = 3'b100,
		RSHC_SEL_IMSK  = 3'b101,
		RSHC_SEL_STATE = 3'b110
	} rshc_sel_t;

endpackage : rshc_pkg

/* rshc_cfg_if.sv */
/*
 * Interface carrying configuration fields from the register bank to the
 * two decode modules and their results back. Assumes one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

interface rshc_cfg_if;
	logic [2:0]                slot_code;
	logic                      hw_assigned;
	logic [1:0]                slp_mode_code;
	logic [6:0]                slp_vcode;
	rshc_pkg::rshc_slp_act_t   slp_act;
	logic [2:0]                slp_slot;
	rshc_pkg::rshc_conv_mode_t slp_mode;
	logic [11:0]               slp_mv;
	logic [1:0]                src;
	logic                      hw1;
	logic                      hw2;
	logic                      vpick;
	logic [4:0]                on_code;
	logic [4:0]                slp_code;
	logic [1:0]                hwc_mode;
	logic                      on_mode;
	logic                      flt;
	logic                      seq_en;
	logic                      shut;
	logic                      hw_active;
	logic                      en;
	logic [4:0]                vcode;
	logic                      low_power;
	logic                      disch;

	modport bank (output slot_code, hw_assigned, slp_mode_code, slp_vcode, src, hw1, hw2,
		vpick, on_code, slp_code, hwc_mode, on_mode, flt, seq_en, shut,
		input slp_act, slp_slot, slp_mode, slp_mv, hw_active, en, vcode, low_power, disch);
	modport conv (input slot_code, hw_assigned, slp_mode_code, slp_vcode,
		output slp_act, slp_slot, slp_mode, slp_mv);
	modport regl (input src, hw1, hw2, vpick, on_code, slp_code, hwc_mode, on_mode, flt,
		seq_en, shut, output hw_active, en, vcode, low_power, disch);
endinterface : rshc_cfg_if

`default_nettype wire

/* rshc_conv_sleep.sv */
/*
 * Decodes the converter sleep slot, operating mode and voltage code.
 * Assumes fields arrive stable from the register bank on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rshc_consts.svh"

module rshc_conv_sleep (
	rshc_cfg_if.conv c
);
	logic [6:0] code_sat;

	always_comb begin
		c.slp_slot = 3'h5;
		c.slp_act  = rshc_pkg::RSHC_ACT_TRANSITION;
		case (c.slot_code)
			3'h0: c.slp_slot = 3'h5;
			3'h6: c.slp_slot = 3'h3;
			3'h7: c.slp_slot = 3'h1;
			default: begin
				// Codes 1..5 walk from slot 5 down to slot 1
				c.slp_slot = 3'h6 - c.slot_code;
				c.slp_act  = c.hw_assigned ? rshc_pkg::RSHC_ACT_ENTER
					: rshc_pkg::RSHC_ACT_DISABLE;
			end
		endcase
		c.slp_mode = rshc_pkg::rshc_conv_mode_t'(c.slp_mode_code);
		code_sat   = (c.slp_vcode > `RSHC_CONV_SAT_CODE) ? `RSHC_CONV_SAT_CODE : c.slp_vcode;
		c.slp_mv   = `RSHC_CONV_BASE_MV + 12'(code_sat * `RSHC_CONV_STEP_MV);
	end
endmodule : rshc_conv_sleep

`default_nettype wire

/* rshc_reg_ctrl.sv */
/*
 * Resolves the regulator's hardware control: source, voltage and mode.
 * Assumes hardware control inputs are already synchronised.
 */
`timescale 1ns/1ps
`default_nettype none

module rshc_reg_ctrl (
	rshc_cfg_if.regl r
);
	always_comb begin
		case (r.src)
			2'b01:   r.hw_active = r.hw1;
			2'b10:   r.hw_active = r.hw2;
			2'b11:   r.hw_active = r.hw1 | r.hw2;
			default: r.hw_active = 1'b0;
		endcase
		r.en        = r.seq_en;
		r.low_power = r.on_mode;
		r.vcode     = r.on_code;
		if (r.hw_active) begin
			r.vcode = r.vpick ? r.slp_code : r.on_code;
			case (r.hwc_mode)
				2'b01: begin
					r.en        = 1'b0;
					r.low_power = 1'b0;
				end
				2'b11: begin
					// Mode 11 keeps the regulator running, in its ON mode
					r.en        = 1'b1;
					r.low_power = r.on_mode;
				end
				default: begin
					r.en        = 1'b1;
					r.low_power = 1'b1;
				end
			endcase
		end
		if (r.shut) begin
			r.en = 1'b0;
		end
		r.disch = ~r.en & ~r.flt;
	end
endmodule : rshc_reg_ctrl

`default_nettype wire

/* rshc_top.sv */
/*
 * Register bank for converter sleep control and regulator control, with
 * an APB slave, undervoltage handling and one level interrupt.
 * Assumes sequencer signals share clk_sys; hardware control and
 * undervoltage inputs are asynchronous pins.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rshc_consts.svh"

module rshc_top (
	// Clock, reset, enable
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [17:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Sequencer, same clock
	input  wire logic        seq_sleep,
	input  wire logic        seq_slot_strobe,
	input  wire logic [2:0]  seq_slot_num,
	input  wire logic        conv_hw_assigned,
	input  wire logic        reg_seq_enable,
	// Asynchronous pins
	input  wire logic        hwctl1_pin,
	input  wire logic        hwctl2_pin,
	input  wire logic        reg_uv_pin,
	// Converter sleep outputs
	output logic             conv_sleep_transition,
	output logic             conv_sleep_disable,
	output logic             conv_sleep_enter,
	output logic      [1:0]  conv_sleep_op_mode,
	output logic      [11:0] conv_sleep_mv,
	// Regulator outputs
	output logic             reg_enable,
	output logic      [4:0]  reg_voltage_code,
	output logic             reg_low_power,
	output logic             reg_lp_min_iq,
	output logic             reg_discharge,
	output logic             reg_switch_mode,
	output logic             dev_reset_req,
	// Interrupt
	output logic             irq
);

	rshc_cfg_if cfg ();

	// Register selection from a byte address
	function automatic rshc_pkg::rshc_sel_t sel_of(input logic [17:0] a);
		logic [15:0] idx;
		idx = a[17:2];
		if (a[1:0] != 2'h0) begin
			sel_of = rshc_pkg::RSHC_SEL_NONE;
		end else begin
			case (idx)
				`RSHC_IDX_CONV_SLP: sel_of = rshc_pkg::RSHC_SEL_CS;
				`RSHC_IDX_REG_CTL:  sel_of = rshc_pkg::RSHC_SEL_RC;
				`RSHC_IDX_REG_AUX:  sel_of = rshc_pkg::RSHC_SEL_AUX;
				`RSHC_IDX_IRQ_STS:  sel_of = rshc_pkg::RSHC_SEL_ISTS;
				`RSHC_IDX_IRQ_MSK:  sel_of = rshc_pkg::RSHC_SEL_IMSK;
				`RSHC_IDX_STATE:    sel_of = rshc_pkg::RSHC_SEL_STATE;
				default:            sel_of = rshc_pkg::RSHC_SEL_NONE;
			endcase
		end
	endfunction : sel_of

	// Byte-lane merge, then keep only defined bits
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] st, input logic [31:0] msk);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				m[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		merge = m & msk;
	endfunction : merge

	// Pin synchronisers
	logic [2:0] pin_s1_q;
	logic [2:0] pin_s1_d;
	logic [2:0] pin_s2_q;
	logic [2:0] pin_s2_d;

	always_comb begin
		pin_s1_d = {reg_uv_pin, hwctl2_pin, hwctl1_pin};
		pin_s2_d = pin_s1_q;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pin_s1_q <= 3'h0;
			pin_s2_q <= 3'h0;
		end else if (ce) begin
			pin_s1_q <= pin_s1_d;
			pin_s2_q <= pin_s2_d;
		end
	end

	logic hw1_s;
	logic hw2_s;
	logic uv_s;

	always_comb begin
		hw1_s = pin_s2_q[0];
		hw2_s = pin_s2_q[1];
		uv_s  = pin_s2_q[2];
	end

	// Register bank state
	logic [31:0]         cs_q;
	logic [31:0]         cs_d;
	logic [31:0]         rc_q;
	logic [31:0]         rc_d;
	logic [31:0]         aux_q;
	logic [31:0]         aux_d;
	logic [2:0]          ists_q;
	logic [2:0]          ists_d;
	logic [2:0]          imsk_q;
	logic [2:0]          imsk_d;
	logic                shut_q;
	logic                shut_d;
	logic                uv_prev_q;
	logic                uv_prev_d;
	logic                hwa_prev_q;
	logic                hwa_prev_d;
	logic [31:0]         rdata_q;
	logic [31:0]         rdata_d;
	logic                rerr_q;
	logic                rerr_d;
	logic [2:0]          events;
	logic                wr_en;
	logic                setup;
	rshc_pkg::rshc_sel_t sel;
	rshc_pkg::rshc_err_act_t err_act;
	logic [31:0]         state_word;
	logic                slot_hit;

	// Bank fields onto the decode modules
	always_comb begin
		cfg.slot_code     = cs_q[`RSHC_CS_SLOT];
		cfg.hw_assigned   = conv_hw_assigned;
		cfg.slp_mode_code = cs_q[`RSHC_CS_MODE];
		cfg.slp_vcode     = cs_q[`RSHC_CS_VSEL];
		cfg.src           = rc_q[`RSHC_RC_SRC];
		cfg.hw1           = hw1_s;
		cfg.hw2           = hw2_s;
		cfg.vpick         = rc_q[`RSHC_RC_VPICK];
		cfg.on_code       = aux_q[`RSHC_AUX_ONV];
		cfg.slp_code      = aux_q[`RSHC_AUX_SLPV];
		cfg.hwc_mode      = rc_q[`RSHC_RC_HWMODE];
		cfg.on_mode       = aux_q[`RSHC_AUX_ONMODE];
		cfg.flt           = rc_q[`RSHC_RC_FLOAT];
		cfg.seq_en        = reg_seq_enable;
		cfg.shut          = shut_q;
	end

	rshc_conv_sleep u_conv (
		.c (cfg.conv)
	);

	rshc_reg_ctrl u_regl (
		.r (cfg.regl)
	);

	// Bus decode; zero wait states, data captured in the setup cycle
	always_comb begin
		setup  = psel & ~penable;
		sel    = sel_of(paddr);
		wr_en  = psel & penable & pwrite & (sel != rshc_pkg::RSHC_SEL_NONE);
		pready = 1'b1;
		prdata = rdata_q;
		pslverr = psel & penable & rerr_q;
	end

	always_comb begin
		state_word = {26'h0, shut_q, uv_s, hw2_s, hw1_s, cfg.en, cfg.hw_active};
		rdata_d    = rdata_q;
		rerr_d     = rerr_q;
		if (setup) begin
			rerr_d = (sel == rshc_pkg::RSHC_SEL_NONE);
			case (sel)
				rshc_pkg::RSHC_SEL_CS:    rdata_d = cs_q;
				rshc_pkg::RSHC_SEL_RC:    rdata_d = rc_q;
				rshc_pkg::RSHC_SEL_AUX:   rdata_d = aux_q;
				rshc_pkg::RSHC_SEL_ISTS:  rdata_d = {29'h0, ists_q};
				rshc_pkg::RSHC_SEL_IMSK:  rdata_d = {29'h0, imsk_q};
				rshc_pkg::RSHC_SEL_STATE: rdata_d = state_word;
				default:                  rdata_d = 32'h0;
			endcase
		end
	end

	// Register writes and event tracking
	always_comb begin
		cs_d       = cs_q;
		rc_d       = rc_q;
		aux_d      = aux_q;
		imsk_d     = imsk_q;
		err_act    = rshc_pkg::rshc_err_act_t'(rc_q[`RSHC_RC_ERR]);
		uv_prev_d  = uv_s;
		hwa_prev_d = cfg.hw_active;
		slot_hit   = seq_sleep & seq_slot_strobe & (seq_slot_num == cfg.slp_slot);
		events     = 3'h0;
		events[`RSHC_IRQ_UV]   = uv_s & ~uv_prev_q;
		events[`RSHC_IRQ_SLOT] = slot_hit;
		events[`RSHC_IRQ_HWC]  = cfg.hw_active & ~hwa_prev_q;
		if (wr_en) begin
			case (sel)
				rshc_pkg::RSHC_SEL_CS:   cs_d  = merge(cs_q, pwdata, pstrb, `RSHC_CS_MASK);
				rshc_pkg::RSHC_SEL_RC:   rc_d  = merge(rc_q, pwdata, pstrb, `RSHC_RC_MASK);
				rshc_pkg::RSHC_SEL_AUX:  aux_d = merge(aux_q, pwdata, pstrb, `RSHC_AUX_MASK);
				rshc_pkg::RSHC_SEL_IMSK: imsk_d = imsk_q;
				default:                 cs_d  = cs_q;
			endcase
			if (sel == rshc_pkg::RSHC_SEL_IMSK && pstrb[0]) begin
				imsk_d = pwdata[2:0];
			end
		end
		// Write one clears; a same-cycle event wins
		ists_d = ists_q;
		if (wr_en && sel == rshc_pkg::RSHC_SEL_ISTS && pstrb[0]) begin
			ists_d = ists_q & ~pwdata[2:0];
		end
		ists_d = ists_d | events;
		// Shutdown holds until the undervoltage status is cleared
		shut_d = shut_q;
		if (!ists_d[`RSHC_IRQ_UV]) begin
			shut_d = 1'b0;
		end
		if (events[`RSHC_IRQ_UV] && err_act == rshc_pkg::RSHC_ERR_SHUT) begin
			shut_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cs_q       <= `RSHC_CS_RESET;
			rc_q       <= `RSHC_RC_RESET;
			aux_q      <= `RSHC_AUX_RESET;
			ists_q     <= `RSHC_IRQ_RESET;
			imsk_q     <= `RSHC_IRQ_RESET;
			shut_q     <= 1'b0;
			uv_prev_q  <= 1'b0;
			hwa_prev_q <= 1'b0;
			rdata_q    <= 32'h0;
			rerr_q     <= 1'b0;
		end else if (ce) begin
			cs_q       <= cs_d;
			rc_q       <= rc_d;
			aux_q      <= aux_d;
			ists_q     <= ists_d;
			imsk_q     <= imsk_d;
			shut_q     <= shut_d;
			uv_prev_q  <= uv_prev_d;
			hwa_prev_q <= hwa_prev_d;
			rdata_q    <= rdata_d;
			rerr_q     <= rerr_d;
		end
	end

	// Registered outputs
	logic        trans_d;
	logic        disab_d;
	logic        enter_d;
	logic        rst_req_d;
	logic        irq_d;
	logic        trans_q;
	logic        disab_q;
	logic        enter_q;
	logic [1:0]  mode_q;
	logic [11:0] mv_q;
	logic        en_q;
	logic [4:0]  vcode_q;
	logic        lowp_q;
	logic        lpmin_q;
	logic        disch_q;
	logic        sw_q;
	logic        rst_req_q;
	logic        irq_q;

	always_comb begin
		trans_d   = slot_hit & (cfg.slp_act == rshc_pkg::RSHC_ACT_TRANSITION);
		disab_d   = slot_hit & (cfg.slp_act == rshc_pkg::RSHC_ACT_DISABLE);
		enter_d   = slot_hit & (cfg.slp_act == rshc_pkg::RSHC_ACT_ENTER);
		rst_req_d = events[`RSHC_IRQ_UV] & (err_act == rshc_pkg::RSHC_ERR_RESET);
		irq_d     = |(ists_d & imsk_d);
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			trans_q   <= 1'b0;
			disab_q   <= 1'b0;
			enter_q   <= 1'b0;
			mode_q    <= `RSHC_CS_MODE_RESET;
			mv_q      <= `RSHC_CONV_BASE_MV;
			en_q      <= 1'b0;
			vcode_q   <= 5'h00;
			lowp_q    <= 1'b0;
			lpmin_q   <= 1'b0;
			disch_q   <= 1'b0;
			sw_q      <= 1'b0;
			rst_req_q <= 1'b0;
			irq_q     <= 1'b0;
		end else if (ce) begin
			trans_q   <= trans_d;
			disab_q   <= disab_d;
			enter_q   <= enter_d;
			mode_q    <= cfg.slp_mode;
			mv_q      <= cfg.slp_mv;
			en_q      <= cfg.en;
			vcode_q   <= cfg.vcode;
			lowp_q    <= cfg.low_power;
			lpmin_q   <= rc_q[`RSHC_RC_LPSEL];
			disch_q   <= cfg.disch;
			sw_q      <= rc_q[`RSHC_RC_SWITCH];
			rst_req_q <= rst_req_d;
			irq_q     <= irq_d;
		end
	end

	always_comb begin
		conv_sleep_transition = trans_q;
		conv_sleep_disable    = disab_q;
		conv_sleep_enter      = enter_q;
		conv_sleep_op_mode    = mode_q;
		conv_sleep_mv         = mv_q;
		reg_enable            = en_q;
		reg_voltage_code      = vcode_q;
		reg_low_power         = lowp_q;
		reg_lp_min_iq         = lpmin_q;
		reg_discharge         = disch_q;
		reg_switch_mode       = sw_q;
		dev_reset_req         = rst_req_q;
		irq                   = irq_q;
	end

endmodule : rshc_top

`default_nettype wire

/* rshc_top_props.sv */
/*
 * Checker with concurrent properties on the top module's ports.
 * Assumes one clock domain, clk_sys, with synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module rshc_props (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rst_n,
	// Bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	// Sequencer
	input wire logic        seq_sleep,
	input wire logic        seq_slot_strobe,
	input wire logic [2:0]  seq_slot_num,
	input wire logic        conv_hw_assigned,
	// Outputs
	input wire logic        conv_sleep_transition,
	input wire logic        conv_sleep_disable,
	input wire logic        conv_sleep_enter,
	input wire logic [11:0] conv_sleep_mv,
	input wire logic        reg_enable,
	input wire logic        reg_discharge,
	input wire logic        dev_reset_req
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	chk_ready_always: assert property (pready)
		else $error("pready low");
	chk_err_access_only: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access phase");
	chk_trans_slot_cause: assert property (conv_sleep_transition |->
		$past(seq_sleep) && $past(seq_slot_strobe) && ($past(seq_slot_num) inside {3'h1, 3'h3, 3'h5}))
		else $error("transition pulse without matching slot");
	chk_trans_one_cycle: assert property (conv_sleep_transition |=> !conv_sleep_transition)
		else $error("transition pulse too long");
	chk_disable_no_hw: assert property (conv_sleep_disable |->
		!$past(conv_hw_assigned) && $past(seq_slot_strobe) && $past(seq_sleep))
		else $error("disable pulse with hardware enable assigned");
	chk_enter_with_hw: assert property (conv_sleep_enter |->
		$past(conv_hw_assigned) && $past(seq_slot_strobe) && $past(seq_sleep))
		else $error("enter pulse without hardware enable");
	chk_action_exclusive: assert property ($onehot0({conv_sleep_transition,
		conv_sleep_disable, conv_sleep_enter}))
		else $error("two sleep actions at once");
	chk_mv_scale_step: assert property (conv_sleep_mv >= 12'h352 && conv_sleep_mv <= 12'hD48
		&& ((conv_sleep_mv - 12'h352) % 12'h019) == 12'h000)
		else $error("sleep millivolts off scale");
	chk_reset_req_pulse: assert property (dev_reset_req |=> !dev_reset_req)
		else $error("reset request too long");
	chk_discharge_off: assert property (reg_discharge |-> !reg_enable)
		else $error("discharge while enabled");

	cov_transition: cover property (conv_sleep_transition);
	cov_enter: cover property (conv_sleep_enter);
	cov_reset_req: cover property (dev_reset_req);
endmodule : rshc_props

bind rshc_top rshc_props u_props (
	.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .seq_sleep(seq_sleep), .seq_slot_strobe(seq_slot_strobe),
	.seq_slot_num(seq_slot_num), .conv_hw_assigned(conv_hw_assigned),
	.conv_sleep_transition(conv_sleep_transition), .conv_sleep_disable(conv_sleep_disable),
	.conv_sleep_enter(conv_sleep_enter), .conv_sleep_mv(conv_sleep_mv),
	.reg_enable(reg_enable), .reg_discharge(reg_discharge), .dev_reset_req(dev_reset_req)
);

`default_nettype wire

/* tb_top.sv */
/*
 * Self-checking bench driving the register bank over APB and its pins.
 * Assumes zero-wait APB slave and registered outputs a few cycles late.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rshc_consts.svh"

module tb_top;
	localparam logic [17:0] CS  = {`RSHC_IDX_CONV_SLP, 2'b00};
	localparam logic [17:0] RC  = {`RSHC_IDX_REG_CTL, 2'b00};
	localparam logic [17:0] AUX = {`RSHC_IDX_REG_AUX, 2'b00};
	localparam logic [17:0] STS = {`RSHC_IDX_IRQ_STS, 2'b00};
	localparam logic [17:0] MSK = {`RSHC_IDX_IRQ_MSK, 2'b00};
	logic        clk_sys = 1'b0, rst_n = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [17:0] paddr = 18'h00000;
	logic [31:0] pwdata = 32'h00000000, prdata;
	logic        pready, pslverr;
	logic        seq_sleep = 1'b0, seq_slot_strobe = 1'b0, conv_hw_assigned = 1'b0;
	logic [2:0]  seq_slot_num = 3'h0;
	logic        reg_seq_enable = 1'b0, hwctl1_pin = 1'b0, hwctl2_pin = 1'b0, reg_uv_pin = 1'b0;
	logic        c_tr, c_dis, c_ent, reg_enable, reg_low_power, reg_lp_min_iq;
	logic        reg_discharge, reg_switch_mode, dev_reset_req, irq;
	logic [1:0]  c_mode;
	logic [11:0] c_mv;
	logic [4:0]  reg_voltage_code;
	logic        onm = 1'b0;
	int          num_errors = 0, cmp_count = 0, resets = 0;

	rshc_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .seq_sleep(seq_sleep),
		.seq_slot_strobe(seq_slot_strobe), .seq_slot_num(seq_slot_num),
		.conv_hw_assigned(conv_hw_assigned), .reg_seq_enable(reg_seq_enable),
		.hwctl1_pin(hwctl1_pin), .hwctl2_pin(hwctl2_pin), .reg_uv_pin(reg_uv_pin),
		.conv_sleep_transition(c_tr), .conv_sleep_disable(c_dis), .conv_sleep_enter(c_ent),
		.conv_sleep_op_mode(c_mode), .conv_sleep_mv(c_mv), .reg_enable(reg_enable),
		.reg_voltage_code(reg_voltage_code), .reg_low_power(reg_low_power),
		.reg_lp_min_iq(reg_lp_min_iq), .reg_discharge(reg_discharge),
		.reg_switch_mode(reg_switch_mode), .dev_reset_req(dev_reset_req), .irq(irq));

	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (dev_reset_req === 1'b1) resets <= resets + 1;

	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic check1(input logic got, input logic exp);
		check({31'h0, got}, {31'h0, exp});
	endtask : check1

	task automatic waitc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : waitc

	task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		if (n >= 16) num_errors++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [17:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, a, d, rd, err);
	endtask : wr

	task automatic rdchk(input logic [17:0] a, input logic [31:0] exp, input logic exp_err);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, 32'h0, rd, err);
		check(rd, exp);
		check1(err, exp_err);
	endtask : rdchk

	task automatic slot_run(input logic [2:0] code, input logic hw);
		logic tr, dis;
		wr(CS, {16'h0, code, 13'h0000});
		conv_hw_assigned <= hw;
		for (int s = 1; s <= 5; s++) begin
			tr = (code == 3'h0 && s == 5) || (code == 3'h6 && s == 3) || (code == 3'h7 && s == 1);
			dis = (code >= 3'h1 && code <= 3'h5 && s == 6 - code);
			@(posedge clk_sys);
			seq_slot_strobe <= 1'b1;
			seq_slot_num <= s[2:0];
			@(posedge clk_sys);
			seq_slot_strobe <= 1'b0;
			@(posedge clk_sys);
			check({c_tr, c_dis, c_ent}, {tr, dis & !hw, dis & hw});
		end
	endtask : slot_run

	task automatic hw_case(input logic [1:0] src, input logic h1, h2, vp, input logic [1:0] md,
		input logic flt, sw, lp);
		logic en, lpw;
		en = ((src[0] & h1) | (src[1] & h2)) && md != 2'b01;
		lpw = (md == 2'b11) ? onm : 1'b1;
		wr(RC, {16'h0, 3'h0, src, vp, md, flt, sw, 5'h00, lp});
		hwctl1_pin <= h1;
		hwctl2_pin <= h2;
		waitc(6);
		check1(reg_enable, en);
		check1(reg_discharge, !en && !flt);
		check1(reg_switch_mode, sw);
		if (en) begin
			check({27'h0, reg_voltage_code}, vp ? 32'h0000000A : 32'h00000005);
			check1(reg_low_power, lpw);
			if (lpw) check1(reg_lp_min_iq, lp);
		end
	endtask : hw_case

	task automatic uv_run(input logic [1:0] act);
		int   r0;
		logic i0;
		wr(RC, {16'h0, act, 14'h0000});
		wr(STS, 32'h00000007);
		r0 = resets;
		reg_uv_pin <= 1'b1;
		waitc(8);
		reg_uv_pin <= 1'b0;
		rdchk(STS, 32'h00000001, 1'b0);
		check1(reg_enable, act != 2'b01);
		check(resets - r0, (act == 2'b10) ? 32'h1 : 32'h0);
		wr(MSK, 32'h00000000);
		waitc(2);
		i0 = irq;
		wr(MSK, 32'h00000007);
		waitc(2);
		check1(i0, 1'b0);
		check1(irq, 1'b1);
		wr(STS, 32'h00000001);
		waitc(3);
		check1(irq, 1'b0);
		check1(reg_enable, 1'b1);
	endtask : uv_run

	initial begin
		static logic [6:0] vt [5] = '{7'h00, 7'h01, 7'h65, 7'h66, 7'h7F};
		logic [6:0] v;
		waitc(6);
		rst_n <= 1'b1;
		rdchk(CS, 32'h00000300, 1'b0);
		rdchk(RC, 32'h00000200, 1'b0);
		check({30'h0, c_mode}, 32'h00000003);
		check({20'h0, c_mv}, 32'h00000352);
		wr(CS, 32'hFFFFFFFF);
		rdchk(CS, 32'h0000E37F, 1'b0);
		wr(RC, 32'hFFFFFFFF);
		rdchk(RC, 32'h0000DFC1, 1'b0);
		rdchk(RC + 18'h00004, 32'h00000000, 1'b1);
		wr(CS + 18'h00002, 32'h00000000);
		rdchk(CS, 32'h0000E37F, 1'b0);
		wr(RC, 32'h00000000);
		for (int i = 0; i < 5; i++) begin
			v = vt[i];
			wr(CS, {22'h0, i[1:0], 1'b0, v});
			waitc(3);
			check({30'h0, c_mode}, {30'h0, i[1:0]});
			check({20'h0, c_mv}, 32'h352 + 32'h19 * ((v >= 7'h66) ? 32'h66 : {25'h0, v}));
		end
		seq_sleep <= 1'b1;
		for (int k = 0; k < 16; k++) slot_run(k[2:0], k[3]);
		seq_sleep <= 1'b0;
		conv_hw_assigned <= 1'b0;
		onm = 1'b1;
		wr(AUX, 32'h00010A05);
		hw_case(2'b00, 1'b1, 1'b1, 1'b0, 2'b00, 1'b0, 1'b0, 1'b0);
		hw_case(2'b01, 1'b1, 1'b0, 1'b0, 2'b00, 1'b0, 1'b0, 1'b0);
		hw_case(2'b01, 1'b0, 1'b1, 1'b1, 2'b10, 1'b1, 1'b1, 1'b1);
		hw_case(2'b10, 1'b0, 1'b1, 1'b1, 2'b10, 1'b0, 1'b0, 1'b1);
		hw_case(2'b10, 1'b1, 1'b0, 1'b0, 2'b01, 1'b0, 1'b0, 1'b0);
		hw_case(2'b11, 1'b1, 1'b0, 1'b0, 2'b01, 1'b0, 1'b0, 1'b0);
		hw_case(2'b11, 1'b0, 1'b1, 1'b0, 2'b11, 1'b0, 1'b0, 1'b0);
		onm = 1'b0;
		wr(AUX, 32'h00000A05);
		hw_case(2'b11, 1'b1, 1'b1, 1'b1, 2'b11, 1'b1, 1'b0, 1'b1);
		hwctl1_pin <= 1'b0;
		hwctl2_pin <= 1'b0;
		reg_seq_enable <= 1'b1;
		for (int a = 0; a < 4; a++) uv_run(a[1:0]);
		test_done();
	end

	initial begin
		#400000;
		num_errors++;
		test_done();
	end
endmodule : tb_top

`default_nettype wire
